// File: pkg/iat_pkg.sv
// constants, types and register map of the acquisition and trigger sequencer
// assumes one 200 MHz clock and an AXI4-Lite master with 32-bit data

package iat_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          IAT_CLK_PERIOD_NS = 5;
	localparam int          IAT_NS_PER_US     = 1000;
	localparam logic [39:0] IAT_CYC_PER_US    =
		40'(IAT_NS_PER_US / IAT_CLK_PERIOD_NS);
	localparam logic [7:0]  IAT_SUB_LAST      = 8'(IAT_CYC_PER_US - 40'h1);

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] IAT_OFF_CTRL   = 8'h00;
	localparam logic [7:0] IAT_OFF_CMD    = 8'h04;
	localparam logic [7:0] IAT_OFF_MULTI  = 8'h08;
	localparam logic [7:0] IAT_OFF_BURST  = 8'h0C;
	localparam logic [7:0] IAT_OFF_EXPO   = 8'h10;
	localparam logic [7:0] IAT_OFF_DELAY  = 8'h14;
	localparam logic [7:0] IAT_OFF_PERIOD = 8'h18;
	localparam logic [7:0] IAT_OFF_STATUS = 8'h1C;
	localparam logic [7:0] IAT_OFF_ACHV   = 8'h20;
	localparam logic [7:0] IAT_OFF_FRAMES = 8'h24;
	localparam logic [7:0] IAT_OFF_AEXP   = 8'h28;

	localparam int IAT_CMD_BEGIN = 0;
	localparam int IAT_CMD_END   = 1;
	localparam int IAT_CMD_SOFT  = 2;

	localparam logic [1:0] IAT_RESP_OKAY   = 2'h0;
	localparam logic [1:0] IAT_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// modes and selectors
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IAT_CAP_CONT = 2'h0, IAT_CAP_ONE = 2'h1, IAT_CAP_COUNTED = 2'h2
	} iat_mode_t;
	typedef enum logic [1:0] {
		IAT_AE_OFF = 2'h0, IAT_AE_ONCE = 2'h1, IAT_AE_CONT = 2'h2
	} iat_ae_t;
	typedef enum logic [1:0] {
		IAT_TT_START = 2'h0, IAT_TT_IMAGE = 2'h1, IAT_TT_BURST = 2'h2
	} iat_ttype_t;
	typedef enum logic [2:0] {
		IAT_OR_LINE0 = 3'h0, IAT_OR_LINE1 = 3'h1, IAT_OR_USER = 3'h2,
		IAT_OR_COUNTER = 3'h3, IAT_OR_LOGIC = 3'h4, IAT_OR_SOFT = 3'h5
	} iat_origin_t;
	typedef enum logic [2:0] {
		IAT_SN_LOW = 3'h0, IAT_SN_HIGH = 3'h1, IAT_SN_FALL = 3'h2,
		IAT_SN_RISE = 3'h3, IAT_SN_ANY = 3'h4
	} iat_sense_t;
	typedef enum logic [2:0] {
		IAT_S_IDLE = 3'b000, IAT_S_WAIT = 3'b001, IAT_S_DELAY = 3'b011,
		IAT_S_EXPOSE = 3'b010, IAT_S_PACE = 3'b110
	} iat_state_t;

	typedef struct packed {
		logic        burst_end_en;
		logic        burst_begin_en;
		logic        overlap;
		iat_sense_t  sense;
		iat_origin_t origin;
		iat_ttype_t  ttype;
		logic        trig_en;
		iat_ae_t     auto_exp;
		logic        pulse_exp;
		logic        rate_hold;
		logic        manual_rate;
		iat_mode_t   mode;
	} iat_ctrl_t;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [18:0] IAT_CTRL_RST   = 19'h20040;
	localparam logic [31:0] IAT_MULTI_RST  = 32'h0000_0001;
	localparam logic [31:0] IAT_BURST_RST  = 32'h0000_0001;
	localparam logic [31:0] IAT_EXPO_RST   = 32'h0000_03E8;
	localparam logic [31:0] IAT_DELAY_RST  = 32'h0000_0000;
	localparam logic [31:0] IAT_PERIOD_RST = 32'h0000_8235;

endpackage

// File: verilog/iat_sequencer.sv
// acquisition sequencer with trigger unit and AXI4-Lite register slave
// assumes trigger inputs synchronous to clk_sys and an outside auto exposure
// engine presenting its suggestion in microseconds on ae_suggest
`timescale 1ns/1ps
`default_nettype none

module iat_sequencer
	import iat_pkg::*;
#(
	parameter int READOUT_US = 10
)(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [1:0]  trig_line,
	input  wire logic        trig_user,
	input  wire logic        trig_counter,
	input  wire logic        trig_logic,
	input  wire logic [31:0] ae_suggest,
	output logic             exposure_active,
	output logic             readout_active,
	output logic             frame_start,
	output logic             capture_active
);

	// ----------------------------------------------------------------
	// checks and helpers
	// ----------------------------------------------------------------
	if (READOUT_US < 1) begin : g_chk
		$error("READOUT_US must be at least one");
	end

	localparam logic [31:0] RD_US = 32'(READOUT_US);

	// microseconds to cycles, never below one cycle
	function automatic logic [39:0] cyc(input logic [31:0] us);
		logic [39:0] c;
		c = {8'h00, us} * IAT_CYC_PER_US;
		return (c == 40'h0) ? 40'h1 : c;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// images per trigger or start: {unlimited, count}
	function automatic logic [32:0] quota(input iat_ctrl_t c,
		input logic trig, input logic [31:0] multi, input logic [31:0] burst);
		logic bok;
		bok = c.burst_begin_en && !c.burst_end_en;
		case (c.mode)
			IAT_CAP_ONE:     return {1'b0, 32'h1};
			IAT_CAP_COUNTED: return {1'b0, (multi == 32'h0) ? 32'h1 : multi};
			default:
			begin
				if (!trig || c.ttype == IAT_TT_START)
					return {1'b1, 32'h0};
				else if (c.ttype == IAT_TT_BURST && bok)
					return {1'b0, (burst == 32'h0) ? 32'h1 : burst};
				else
					return {1'b0, 32'h1};
			end
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		iat_state_t  state;
		iat_ctrl_t   ctrl;
		logic [31:0] multi;
		logic [31:0] burst;
		logic [31:0] expo;
		logic [31:0] dly;
		logic [31:0] per;
		logic        act;
		logic        unl;
		logic [31:0] quota;
		logic [39:0] cnt;
		logic [39:0] per_cnt;
		logic [39:0] rd_cnt;
		logic        rd_busy;
		logic        expose;
		logic        frame;
		logic        trig_frame;
		logic        pol;
		logic        prev;
		logic [7:0]  meas_sub;
		logic [31:0] meas_us;
		logic [31:0] achieved;
		logic [31:0] frames;
		logic [31:0] ae_exp;
		logic        aw_hold;
		logic [7:0]  awaddr;
		logic        w_hold;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} iat_st_t;

	iat_st_t     st_ff;
	iat_st_t     nxt_st;
	logic        wr_go;
	logic        beg_cmd;
	logic        end_cmd;
	logic        soft_wr;
	logic        ctrl_wr;
	logic        raw;
	logic        evt;
	logic        accept;
	logic        sf;
	logic        pace_go;
	logic        quota_done;
	logic        rearm;
	logic [7:0]  wa;

	assign wa         = {st_ff.awaddr[7:2], 2'b00};
	assign wr_go      = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
	assign ctrl_wr    = wr_go && wa == IAT_OFF_CTRL;
	assign quota_done = !st_ff.unl && st_ff.quota == 32'h0;
	assign pace_go    = st_ff.per_cnt <= 40'h1;
	assign rearm      = st_ff.ctrl.trig_en && (st_ff.ctrl.ttype == IAT_TT_BURST
		|| (st_ff.ctrl.ttype == IAT_TT_IMAGE
		&& st_ff.ctrl.mode == IAT_CAP_CONT));

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [31:0] qv;
		logic        uv;
		logic [31:0] e;
		logic [31:0] tmp;
		logic [32:0] q;
		qv = st_ff.quota;
		uv = st_ff.unl;
		e = 32'h0;
		tmp = 32'h0;
		q = 33'h0;
		nxt_st = st_ff;
		nxt_st.frame = 1'b0;
		sf = 1'b0;
		accept = 1'b0;

		beg_cmd = wr_go && wa == IAT_OFF_CMD && st_ff.wstrb[0]
			&& st_ff.wdata[IAT_CMD_BEGIN];
		end_cmd = wr_go && wa == IAT_OFF_CMD && st_ff.wstrb[0]
			&& st_ff.wdata[IAT_CMD_END];
		soft_wr = wr_go && wa == IAT_OFF_CMD && st_ff.wstrb[0]
			&& st_ff.wdata[IAT_CMD_SOFT];

		// trigger origin and sense
		unique case (st_ff.ctrl.origin)
			IAT_OR_LINE0:   raw = trig_line[0];
			IAT_OR_LINE1:   raw = trig_line[1];
			IAT_OR_USER:    raw = trig_user;
			IAT_OR_COUNTER: raw = trig_counter;
			IAT_OR_LOGIC:   raw = trig_logic;
			default:        raw = 1'b0;
		endcase
		nxt_st.prev = raw;
		unique case (st_ff.ctrl.sense)
			IAT_SN_LOW:  evt = !raw;
			IAT_SN_HIGH: evt = raw;
			IAT_SN_FALL: evt = st_ff.prev && !raw;
			IAT_SN_RISE: evt = !st_ff.prev && raw;
			IAT_SN_ANY:  evt = st_ff.prev ^ raw;
			default:     evt = 1'b0;
		endcase
		if (st_ff.ctrl.origin == IAT_OR_SOFT)
			evt = soft_wr;
		evt = evt && st_ff.ctrl.trig_en;
		q = quota(st_ff.ctrl, 1'b1, st_ff.multi, st_ff.burst);

		// free-running timers
		if (st_ff.per_cnt != 40'h0)
			nxt_st.per_cnt = st_ff.per_cnt - 40'h1;
		if (st_ff.rd_cnt != 40'h0)
			nxt_st.rd_cnt = st_ff.rd_cnt - 40'h1;
		if (st_ff.meas_sub == IAT_SUB_LAST)
		begin
			nxt_st.meas_sub = 8'h00;
			nxt_st.meas_us = st_ff.meas_us + 32'h1;
		end
		else
			nxt_st.meas_sub = st_ff.meas_sub + 8'h01;

		unique case (st_ff.state)
			IAT_S_IDLE:
			begin
				if (beg_cmd)
				begin
					nxt_st.act = 1'b1;
					if (st_ff.ctrl.trig_en)
						nxt_st.state = IAT_S_WAIT;
					else
					begin
						{uv, qv} = quota(st_ff.ctrl, 1'b0, st_ff.multi,
							st_ff.burst);
						nxt_st.trig_frame = 1'b0;
						sf = 1'b1;
					end
				end
				else if (evt && st_ff.ctrl.ttype == IAT_TT_START)
				begin
					nxt_st.act = 1'b1;
					accept = 1'b1;
				end
			end
			IAT_S_WAIT:
				accept = evt && !(st_ff.rd_busy && !st_ff.ctrl.overlap);
			IAT_S_DELAY:
			begin
				if (st_ff.cnt <= 40'h1)
					sf = 1'b1;
				else
					nxt_st.cnt = st_ff.cnt - 40'h1;
			end
			IAT_S_EXPOSE:
			begin
				if (st_ff.trig_frame && st_ff.ctrl.pulse_exp
					&& st_ff.ctrl.origin != IAT_OR_SOFT)
				begin
					if (raw != st_ff.pol)
					begin
						nxt_st.state = IAT_S_PACE;
						nxt_st.rd_cnt = cyc(RD_US);
					end
				end
				else if (st_ff.cnt <= 40'h1)
				begin
					nxt_st.state = IAT_S_PACE;
					nxt_st.rd_cnt = cyc(RD_US);
				end
				else
					nxt_st.cnt = st_ff.cnt - 40'h1;
			end
			IAT_S_PACE:
			begin
				if (pace_go)
				begin
					if (!quota_done)
					begin
						// free frames wait for readout unless overlapping
						if (!st_ff.rd_busy || st_ff.ctrl.overlap)
						begin
							nxt_st.trig_frame = 1'b0;
							sf = 1'b1;
						end
					end
					else if (rearm)
						nxt_st.state = IAT_S_WAIT;
					else
					begin
						nxt_st.state = IAT_S_IDLE;
						nxt_st.act = 1'b0;
					end
				end
			end
			default:
				nxt_st.state = IAT_S_IDLE;
		endcase

		if (accept)
		begin
			{uv, qv} = q;
			nxt_st.cnt = cyc(st_ff.dly);
			nxt_st.pol = raw;
			nxt_st.trig_frame = 1'b1;
			nxt_st.state = IAT_S_DELAY;
		end

		if (sf)
		begin
			nxt_st.state = IAT_S_EXPOSE;
			nxt_st.frame = 1'b1;
			nxt_st.frames = st_ff.frames + 32'h1;
			nxt_st.achieved = nxt_st.meas_us;
			nxt_st.meas_sub = 8'h00;
			nxt_st.meas_us = 32'h0;
			if (!uv)
				qv = qv - 32'h1;
			e = st_ff.expo;
			if (!st_ff.ctrl.pulse_exp && st_ff.ctrl.auto_exp != IAT_AE_OFF)
			begin
				e = ae_suggest;
				nxt_st.ae_exp = ae_suggest;
				if (st_ff.ctrl.auto_exp == IAT_AE_ONCE)
				begin
					nxt_st.ctrl.auto_exp = IAT_AE_OFF;
					nxt_st.expo = ae_suggest;
				end
			end
			else
				nxt_st.ae_exp = st_ff.expo;
			// hold trades exposure length for the programmed frame period
			if (st_ff.ctrl.rate_hold && st_ff.ctrl.manual_rate
				&& e > st_ff.per)
				e = st_ff.per;
			nxt_st.cnt = cyc(e);
			nxt_st.per_cnt = st_ff.ctrl.manual_rate ? cyc(st_ff.per)
				: 40'h0;
		end
		nxt_st.quota = qv;
		nxt_st.unl = uv;

		if (end_cmd)
		begin
			nxt_st.state = IAT_S_IDLE;
			nxt_st.act = 1'b0;
			nxt_st.frame = 1'b0;
		end
		nxt_st.expose = nxt_st.state == IAT_S_EXPOSE;
		nxt_st.rd_busy = nxt_st.rd_cnt != 40'h0;

		// AXI4-Lite write path; software write beats the auto once update
		if (s_axi_awvalid && st_ff.awready)
		begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wready)
		begin
			nxt_st.w_hold = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (st_ff.bvalid && s_axi_bready)
			nxt_st.bvalid = 1'b0;
		if (wr_go)
		begin
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = IAT_RESP_OKAY;
			unique case (wa)
				IAT_OFF_CTRL:
				begin
					tmp = wmerge({13'h0, st_ff.ctrl}, st_ff.wdata,
						st_ff.wstrb);
					nxt_st.ctrl = iat_ctrl_t'(tmp[18:0]);
				end
				IAT_OFF_MULTI:
					nxt_st.multi = wmerge(st_ff.multi, st_ff.wdata, st_ff.wstrb);
				IAT_OFF_BURST:
					nxt_st.burst = wmerge(st_ff.burst, st_ff.wdata, st_ff.wstrb);
				IAT_OFF_EXPO:
					nxt_st.expo = wmerge(st_ff.expo, st_ff.wdata, st_ff.wstrb);
				IAT_OFF_DELAY:
					nxt_st.dly = wmerge(st_ff.dly, st_ff.wdata, st_ff.wstrb);
				IAT_OFF_PERIOD:
					nxt_st.per = wmerge(st_ff.per, st_ff.wdata, st_ff.wstrb);
				IAT_OFF_CMD, IAT_OFF_STATUS, IAT_OFF_ACHV, IAT_OFF_FRAMES,
				IAT_OFF_AEXP: ;
				default:
					nxt_st.bresp = IAT_RESP_SLVERR;
			endcase
		end
		nxt_st.awready = !nxt_st.aw_hold && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_hold && !nxt_st.bvalid;

		// AXI4-Lite read path
		if (st_ff.rvalid && s_axi_rready)
			nxt_st.rvalid = 1'b0;
		if (s_axi_arvalid && st_ff.arready)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = IAT_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				IAT_OFF_CTRL:   nxt_st.rdata = {13'h0, st_ff.ctrl};
				IAT_OFF_CMD:    nxt_st.rdata = 32'h0;
				IAT_OFF_MULTI:  nxt_st.rdata = st_ff.multi;
				IAT_OFF_BURST:  nxt_st.rdata = st_ff.burst;
				IAT_OFF_EXPO:   nxt_st.rdata = st_ff.expo;
				IAT_OFF_DELAY:  nxt_st.rdata = st_ff.dly;
				IAT_OFF_PERIOD: nxt_st.rdata = st_ff.per;
				IAT_OFF_STATUS: nxt_st.rdata = {26'h0, st_ff.expose,
					st_ff.rd_busy, st_ff.state, st_ff.act};
				IAT_OFF_ACHV:   nxt_st.rdata = st_ff.achieved;
				IAT_OFF_FRAMES: nxt_st.rdata = st_ff.frames;
				IAT_OFF_AEXP:   nxt_st.rdata = st_ff.ae_exp;
				default:
				begin
					nxt_st.rdata = 32'h0;
					nxt_st.rresp = IAT_RESP_SLVERR;
				end
			endcase
		end
		nxt_st.arready = !nxt_st.rvalid;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff <= '0;
			st_ff.state <= IAT_S_IDLE;
			st_ff.ctrl <= iat_ctrl_t'(IAT_CTRL_RST);
			st_ff.multi <= IAT_MULTI_RST;
			st_ff.burst <= IAT_BURST_RST;
			st_ff.expo <= IAT_EXPO_RST;
			st_ff.dly <= IAT_DELAY_RST;
			st_ff.per <= IAT_PERIOD_RST;
		end
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready   = st_ff.awready;
	assign s_axi_wready    = st_ff.wready;
	assign s_axi_bvalid    = st_ff.bvalid;
	assign s_axi_bresp     = st_ff.bresp;
	assign s_axi_arready   = st_ff.arready;
	assign s_axi_rvalid    = st_ff.rvalid;
	assign s_axi_rdata     = st_ff.rdata;
	assign s_axi_rresp     = st_ff.rresp;
	assign exposure_active = st_ff.expose;
	assign readout_active  = st_ff.rd_busy;
	assign frame_start     = st_ff.frame;
	assign capture_active  = st_ff.act;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	AST_CONT_RUNS: assert property (st_ff.state == IAT_S_PACE && st_ff.unl
		&& !end_cmd |=> st_ff.act && st_ff.state != IAT_S_IDLE)
		else $error("unlimited capture ended by itself");
	AST_COUNT_ENDS: assert property (st_ff.state == IAT_S_PACE && pace_go
		&& quota_done && !rearm && !end_cmd |=> !capture_active)
		else $error("capture did not end after last image");
	AST_ONE_LOAD: assert property (accept && !end_cmd
		&& st_ff.ctrl.mode == IAT_CAP_ONE |=> st_ff.quota == 32'h1 && !st_ff.unl)
		else $error("one-shot trigger did not load one image");
	AST_AUTO_RATE: assert property (sf && !st_ff.ctrl.manual_rate
		|=> st_ff.per_cnt == 40'h0)
		else $error("automatic rate still paced");
	AST_TIMED_EXPO: assert property (sf && !end_cmd && !st_ff.ctrl.pulse_exp
		&& st_ff.ctrl.auto_exp == IAT_AE_OFF && !st_ff.ctrl.rate_hold
		|=> exposure_active && st_ff.cnt == cyc($past(st_ff.expo)))
		else $error("timed exposure length wrong");
	AST_AE_ONCE: assert property (sf && !ctrl_wr && !st_ff.ctrl.pulse_exp
		&& !(wr_go && wa == IAT_OFF_EXPO)
		&& st_ff.ctrl.auto_exp == IAT_AE_ONCE
		|=> st_ff.ctrl.auto_exp == IAT_AE_OFF && st_ff.expo == $past(ae_suggest))
		else $error("auto once did not fall back to off");
	AST_TRIG_OFF: assert property (st_ff.state == IAT_S_WAIT
		&& !st_ff.ctrl.trig_en |=> st_ff.state != IAT_S_DELAY)
		else $error("trigger taken while disabled");
	AST_NO_OVERLAP: assert property (st_ff.state == IAT_S_WAIT
		&& st_ff.rd_busy && !st_ff.ctrl.overlap |=> st_ff.state != IAT_S_DELAY)
		else $error("trigger taken during readout");
	AST_DELAY_LOAD: assert property (st_ff.state == IAT_S_WAIT
		##1 st_ff.state == IAT_S_DELAY |-> st_ff.cnt == cyc($past(st_ff.dly)))
		else $error("trigger delay not loaded");
	AST_IMAGE_REBEGIN: assert property (st_ff.state == IAT_S_PACE && pace_go
		&& quota_done && st_ff.ctrl.ttype == IAT_TT_IMAGE && !end_cmd
		&& st_ff.ctrl.mode != IAT_CAP_CONT |=> st_ff.state == IAT_S_IDLE)
		else $error("per-image capture kept running without begin");

endmodule

`default_nettype wire

// File: test/iat_partner.sv
// far-side trigger source: one pulse on line 0 per fire request
// assumes requests on clk_sys, spaced wider than one pulse
`timescale 1ns/1ps
`default_nettype none

module iat_partner(
	input  wire logic       clk_sys,
	input  wire logic       fire,
	output logic [1:0]      trig_line
);
	int n = 0;

	// idle low so each pulse gives one clean rising edge
	always @(posedge clk_sys)
	begin
		if (fire)
			n <= 8;
		else if (n > 0)
			n <= n - 1;
		trig_line <= {1'b0, n > 0};
	end
endmodule

`default_nettype wire

// File: test/iat_sequencer_tb.sv
// self-checking bench of the acquisition sequencer
// assumes one 200 MHz clock and the register map of the package
`timescale 1ns/1ps
`default_nettype none

module iat_sequencer_tb;
	import iat_pkg::*;
	localparam int CYC   = IAT_NS_PER_US / IAT_CLK_PERIOD_NS;
	localparam int RO_US = 1;
	logic        clk_sys = 0;
	logic        resetn = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d, seed = 32'h3EE60499, ae = 1;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, fire = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp, trig_line;
	logic        exp_on, rd_on, fr_st, cap_on;
	int          n_errors = 0, checks_done = 0, n_fr = 0, k, m;
	int          n_ex = 0, n_ro = 0, a;

	// ----------------------------------------------------------------
	// harness
	// ----------------------------------------------------------------
	initial forever #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		if (fr_st === 1'b1) n_fr = n_fr + 1;
		if (exp_on === 1'b1) n_ex = n_ex + 1;
		if (rd_on === 1'b1) n_ro = n_ro + 1;
	end
	iat_partner part_u(.clk_sys(clk_sys), .fire(fire),
		.trig_line(trig_line));
	// short readout keeps the run small
	iat_sequencer #(.READOUT_US(RO_US)) dut_u(.clk_sys(clk_sys),
		.resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.trig_line(trig_line), .trig_user(1'b0), .trig_counter(1'b0),
		.trig_logic(1'b0), .ae_suggest(ae), .exposure_active(exp_on),
		.readout_active(rd_on), .frame_start(fr_st),
		.capture_active(cap_on));

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ta && tw))
		begin
			@(posedge clk_sys);
			if (awready === 1'b1 && !ta)
			begin
				ta = 1;
				awvalid <= 0;
			end
			if (wready === 1'b1 && !tw)
			begin
				tw = 1;
				wvalid <= 0;
			end
		end
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		bready <= 0;
		resp = bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		rready <= 0;
		d = rdata;
		resp = rresp;
	endtask

	// c set: also wait for acquisition to end
	task automatic quiet(input logic c);
		int i;
		i = 0;
		do
		begin
			@(posedge clk_sys);
			i++;
		end
		while ((exp_on | rd_on | (cap_on & c)) !== 1'b0 && i < 20000);
		if (i >= 20000)
			n_errors++;
	endtask

	// free run of three frames, then stop and fetch the achieved period
	task automatic run3(input logic [31:0] c, input logic [31:0] e);
		wr(IAT_OFF_EXPO, e);
		wr(IAT_OFF_CTRL, c);
		n_fr = 0;
		wr(IAT_OFF_CMD, 32'h1);
		while (n_fr < 3)
			@(posedge clk_sys);
		wr(IAT_OFF_CMD, 32'h2);
		quiet(1);
		rd(IAT_OFF_ACHV);
	endtask

	// one partner pulse; want is the edge count from fire to frame start
	task automatic pulse(input int want);
		int i;
		i = 0;
		fire <= 1;
		@(posedge clk_sys);
		fire <= 0;
		while (fr_st !== 1'b1)
		begin
			@(posedge clk_sys);
			i++;
		end
		chk(i, want);
		quiet(0);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want)
		begin
			n_errors++;
			$display("ERROR %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// reference: images per start in one-shot or counted capture
	function automatic int model(input int mode, input int cnt);
		return (mode == 1) ? 1 : cnt;
	endfunction

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	initial
	begin
		#400000;
		n_errors++;
		test_done;
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1;
		rd(IAT_OFF_CTRL);
		chk(d, {13'h0, IAT_CTRL_RST});
		rd(IAT_OFF_EXPO);
		chk(d, IAT_EXPO_RST);
		rd(IAT_OFF_MULTI);
		chk(d, IAT_MULTI_RST);
		rd(8'h3C);
		chk(resp, IAT_RESP_SLVERR);
		wr(8'h3C, 32'h1);
		chk(resp, IAT_RESP_SLVERR);
		wr(IAT_OFF_EXPO, 32'h1);
		for (k = 1; k < 3; k++)
		begin
			seed = lfsr(seed);
			m = 2 + seed % 3;
			wr(IAT_OFF_MULTI, m);
			wr(IAT_OFF_CTRL, 32'h00020000 | k);
			n_fr = 0;
			n_ex = 0;
			n_ro = 0;
			wr(IAT_OFF_CMD, 32'h1);
			quiet(1);
			chk(n_fr, model(k, m));
			chk(n_ex, model(k, m) * CYC);
			chk(n_ro, model(k, m) * RO_US * CYC);
		end
		// manual rate, exposure past the period, then rate hold
		wr(IAT_OFF_PERIOD, 32'h3);
		run3(32'h00020004, 32'h1);
		chk(d, 3);
		run3(32'h00020004, 32'h4);
		chk(d, 4 + RO_US);
		run3(32'h0002000C, 32'h4);
		chk(d, 3 + RO_US);
		seed = lfsr(seed);
		a = 1 + seed[1:0];
		ae <= a;
		n_ex = 0;
		wr(IAT_OFF_CTRL, 32'h00020021);
		wr(IAT_OFF_CMD, 32'h1);
		quiet(1);
		chk(n_ex, a * CYC);
		rd(IAT_OFF_EXPO);
		chk(d, a);
		rd(IAT_OFF_CTRL);
		chk(d, 32'h00020001);
		ae <= a + 4;
		wr(IAT_OFF_CTRL, 32'h00020041);
		wr(IAT_OFF_CMD, 32'h1);
		quiet(1);
		rd(IAT_OFF_AEXP);
		chk(d, a + 4);
		rd(IAT_OFF_EXPO);
		chk(d, a);
		n_fr = 0;
		wr(IAT_OFF_CTRL, 32'h00021581);
		wr(IAT_OFF_CMD, 32'h4);
		wr(IAT_OFF_CTRL, 32'h00021401);
		wr(IAT_OFF_CMD, 32'h4);
		quiet(1);
		chk(n_fr, 0);
		wr(IAT_OFF_CTRL, 32'h00021481);
		wr(IAT_OFF_CMD, 32'h4);
		quiet(1);
		chk(n_fr, 1);
		n_fr = 0;
		wr(IAT_OFF_DELAY, 32'h1);
		wr(IAT_OFF_CTRL, 32'h00026180);
		wr(IAT_OFF_CMD, 32'h1);
		pulse(3 + CYC);
		pulse(3 + CYC);
		// falling sense: the partner pulse stays high for 8 cycles
		wr(IAT_OFF_CTRL, 32'h00024180);
		pulse(3 + 8 + CYC);
		chk(n_fr, 3);
		chk(cap_on, 1'b1);
		wr(IAT_OFF_CMD, 32'h2);
		quiet(1);
		chk(cap_on, 1'b0);
		test_done;
	end
endmodule

`default_nettype wire
